/* File: verilog/dual_slope_pwm_timer.sv */
// Dual-slope PWM timer with two compare channels and a capture-top register.
`timescale 1ns/100ps
module dual_slope_pwm_timer
  import dual_slope_pwm_pkg::*;
#(
  parameter int CH = 2
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic [3:0] waveform_mode_field,
  input wire logic [2:0] clock_select,
  input wire logic [1:0] output_behaviour_field_a,
  input wire logic [1:0] output_behaviour_field_b,
  input wire logic pin_direction_bit_a,
  input wire logic pin_direction_bit_b,
  input wire logic compare_a_write,
  input wire logic compare_b_write,
  input wire logic [15:0] compare_write_data,
  input wire logic capture_top_write,
  input wire logic [15:0] capture_top_data,
  input wire logic overflow_flag_clear,
  input wire logic compare_flag_a_clear,
  input wire logic compare_flag_b_clear,
  input wire logic capture_flag_clear,
  output logic [15:0] counter_value,
  output logic count_down,
  output logic [15:0] compare_register_a,
  output logic [15:0] compare_register_b,
  output logic [15:0] capture_top_register,
  output logic overflow_flag,
  output logic compare_flag_a,
  output logic compare_flag_b,
  output logic capture_flag,
  output logic compare_output_a,
  output logic compare_output_b,
  output logic pin_out_a,
  output logic pin_oe_a,
  output logic pin_out_b,
  output logic pin_oe_b
);

  logic [PSC_W-1:0] psc_reg;
  logic tick;
  logic [CNT_W-1:0] cnt_reg;
  dir_t dir_reg;
  logic [CNT_W-1:0] icr_reg;
  logic [CNT_W-1:0] ocr_reg [CH];
  logic [CNT_W-1:0] buf_reg [CH];
  logic oc_reg [CH];
  logic cmp_flag_reg [CH];
  logic pin_out_reg [CH];
  logic pin_oe_reg [CH];
  logic ovf_reg;
  logic icf_reg;
  logic [1:0] behave [CH];
  logic wr [CH];
  logic dirbit [CH];
  logic clr [CH];
  logic match [CH];
  logic is_pc;
  logic is_pfc;
  logic dual;
  logic fixed_top;
  logic top_from_icr;
  logic top_from_a;
  logic [CNT_W-1:0] top_val;
  logic at_top;
  logic at_bottom;
  logic eff_up;

  assign behave[0] = output_behaviour_field_a;
  assign behave[1] = output_behaviour_field_b;
  assign wr[0] = compare_a_write;
  assign wr[1] = compare_b_write;
  assign dirbit[0] = pin_direction_bit_a;
  assign dirbit[1] = pin_direction_bit_b;
  assign clr[0] = compare_flag_a_clear;
  assign clr[1] = compare_flag_b_clear;

  // Mode decode and top selection
  always_comb begin
    is_pc = 1'b0;
    is_pfc = 1'b0;
    fixed_top = 1'b0;
    top_from_icr = 1'b0;
    top_from_a = 1'b0;
    top_val = TOP_8BIT;
    case (waveform_mode_field)
      MODE_PC_8BIT: begin
        is_pc = 1'b1;
        fixed_top = 1'b1;
        top_val = TOP_8BIT;
      end
      MODE_PC_9BIT: begin
        is_pc = 1'b1;
        fixed_top = 1'b1;
        top_val = TOP_9BIT;
      end
      MODE_PC_10BIT: begin
        is_pc = 1'b1;
        fixed_top = 1'b1;
        top_val = TOP_10BIT;
      end
      MODE_PC_CAPTURE: begin
        is_pc = 1'b1;
        top_from_icr = 1'b1;
        top_val = icr_reg;
      end
      MODE_PC_COMPARE_A: begin
        is_pc = 1'b1;
        top_from_a = 1'b1;
        top_val = ocr_reg[0];
      end
      MODE_PFC_CAPTURE: begin
        is_pfc = 1'b1;
        top_from_icr = 1'b1;
        top_val = icr_reg;
      end
      MODE_PFC_COMPARE_A: begin
        is_pfc = 1'b1;
        top_from_a = 1'b1;
        top_val = ocr_reg[0];
      end
      default: begin
        is_pc = 1'b0;
      end
    endcase
  end

  assign dual = is_pc | is_pfc;

  // Prescaled tick as a count enable on the I/O clock
  always_comb begin
    case (clock_select)
      CS_DIV1: tick = 1'b1;
      CS_DIV8: tick = (psc_reg & PSC_MASK_8) == PSC_MASK_8;
      CS_DIV64: tick = (psc_reg & PSC_MASK_64) == PSC_MASK_64;
      CS_DIV256: tick = (psc_reg & PSC_MASK_256) == PSC_MASK_256;
      CS_DIV1024: tick = psc_reg == PSC_MASK_1024;
      default: tick = 1'b0;
    endcase
  end

  // Prescaler counter, cleared while clock select is 0
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      psc_reg <= '0;
    end else if (clk_en) begin
      if (clock_select == 3'h0) begin
        psc_reg <= '0;
      end else begin
        psc_reg <= psc_reg + 10'h001;
      end
    end
  end

  // Turning points of the dual slope
  assign at_top = dual && dir_reg == DIR_UP && cnt_reg == top_val;
  assign at_bottom = dual && dir_reg == DIR_DOWN && cnt_reg == BOTTOM;
  // At the ends the match acts as the slope it is about to enter
  assign eff_up = (cnt_reg == BOTTOM) |
                  (dir_reg == DIR_UP && cnt_reg != top_val);

  // Up/down counter with one-tick dwell at top and bottom
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      cnt_reg <= BOTTOM;
      dir_reg <= DIR_UP;
    end else if (clk_en) begin
      if (!dual) begin
        cnt_reg <= BOTTOM;
        dir_reg <= DIR_UP;
      end else if (tick) begin
        case (dir_reg)
          DIR_UP: begin
            if (cnt_reg == top_val) begin
              dir_reg <= DIR_DOWN;
              cnt_reg <= cnt_reg - 16'h0001;
            end else begin
              cnt_reg <= cnt_reg + 16'h0001;
            end
          end
          DIR_DOWN: begin
            if (cnt_reg == BOTTOM) begin
              dir_reg <= DIR_UP;
              cnt_reg <= cnt_reg + 16'h0001;
            end else begin
              cnt_reg <= cnt_reg - 16'h0001;
            end
          end
          default: begin
            dir_reg <= DIR_UP;
          end
        endcase
      end
    end
  end

  // Capture-top register, not double buffered
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      icr_reg <= '0;
    end else if (clk_en && capture_top_write) begin
      icr_reg <= capture_top_data;
    end
  end

  // Overflow flag at bottom in both modes, set wins over clear
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ovf_reg <= 1'b0;
    end else if (clk_en) begin
      if (tick && at_bottom) begin
        ovf_reg <= 1'b1;
      end else if (overflow_flag_clear) begin
        ovf_reg <= 1'b0;
      end
    end
  end

  // Capture flag when the capture register defines the top
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      icf_reg <= 1'b0;
    end else if (clk_en) begin
      if (tick && at_top && top_from_icr) begin
        icf_reg <= 1'b1;
      end else if (capture_flag_clear) begin
        icf_reg <= 1'b0;
      end
    end
  end

  // Compare channels
  for (genvar i = 0; i < CH; i++) begin : g_ch
    // Match only when the compare value lies within the top
    assign match[i] = tick && dual && cnt_reg == ocr_reg[i] &&
                      ocr_reg[i] <= top_val;

    // Buffer write with masking for fixed tops, load at the turning point
    always_ff @(posedge ref_clk) begin
      if (reset) begin
        buf_reg[i] <= '0;
        ocr_reg[i] <= '0;
      end else if (clk_en) begin
        if (wr[i]) begin
          if (fixed_top) begin
            buf_reg[i] <= compare_write_data & top_val;
          end else begin
            buf_reg[i] <= compare_write_data;
          end
        end
        if (!dual) begin
          ocr_reg[i] <= buf_reg[i];
        end else if (tick && is_pc && at_top) begin
          ocr_reg[i] <= buf_reg[i];
        end else if (tick && is_pfc && at_bottom) begin
          ocr_reg[i] <= buf_reg[i];
        end
      end
    end

    // Compare flag on match, and at top for channel A defining top
    always_ff @(posedge ref_clk) begin
      if (reset) begin
        cmp_flag_reg[i] <= 1'b0;
      end else if (clk_en) begin
        if (match[i]) begin
          cmp_flag_reg[i] <= 1'b1;
        end else if (i == 0 && tick && at_top && top_from_a) begin
          cmp_flag_reg[i] <= 1'b1;
        end else if (clr[i]) begin
          cmp_flag_reg[i] <= 1'b0;
        end
      end
    end

    // Waveform register: clear or set by slope and polarity
    always_ff @(posedge ref_clk) begin
      if (reset) begin
        oc_reg[i] <= 1'b0;
      end else if (clk_en && match[i]) begin
        if (behave[i] == BEHAVE_NON_INVERT) begin
          oc_reg[i] <= !eff_up;
        end else if (behave[i] == BEHAVE_INVERT) begin
          oc_reg[i] <= eff_up;
        end
      end
    end

    // Pin drive enabled by the direction bit with a nonzero output behaviour
    always_ff @(posedge ref_clk) begin
      if (reset) begin
        pin_out_reg[i] <= 1'b0;
        pin_oe_reg[i] <= 1'b0;
      end else if (clk_en) begin
        pin_out_reg[i] <= oc_reg[i];
        pin_oe_reg[i] <= dirbit[i] && behave[i] != 2'h0;
      end
    end
  end

  assign counter_value = cnt_reg;
  assign count_down = dir_reg == DIR_DOWN;
  assign compare_register_a = ocr_reg[0];
  assign compare_register_b = ocr_reg[1];
  assign capture_top_register = icr_reg;
  assign overflow_flag = ovf_reg;
  assign capture_flag = icf_reg;
  assign compare_flag_a = cmp_flag_reg[0];
  assign compare_flag_b = cmp_flag_reg[1];
  assign compare_output_a = oc_reg[0];
  assign compare_output_b = oc_reg[1];
  assign pin_out_a = pin_out_reg[0];
  assign pin_oe_a = pin_oe_reg[0];
  assign pin_out_b = pin_out_reg[1];
  assign pin_oe_b = pin_oe_reg[1];

  // Up-slope steps by one
  property p_up_step;
    @(posedge ref_clk) disable iff (reset)
    clk_en && tick && dual && dir_reg == DIR_UP && cnt_reg != top_val
    |=> cnt_reg == $past(cnt_reg) + 16'h0001;
  endproperty
  a_up_step: assert property (p_up_step)
    else $error("counter did not step up by one");

  // Top held one tick then direction reverses
  property p_top_turn;
    @(posedge ref_clk) disable iff (reset)
    clk_en && tick && at_top |=> dir_reg == DIR_DOWN
    && cnt_reg == $past(cnt_reg) - 16'h0001;
  endproperty
  a_top_turn: assert property (p_top_turn)
    else $error("counter did not turn at top");

  // Overflow flag follows arrival at bottom
  property p_ovf_set;
    @(posedge ref_clk) disable iff (reset)
    clk_en && tick && at_bottom |=> overflow_flag;
  endproperty
  a_ovf_set: assert property (p_ovf_set)
    else $error("overflow flag not set at bottom");

  // Phase correct load at top
  property p_pc_load;
    @(posedge ref_clk) disable iff (reset)
    clk_en && tick && is_pc && at_top
    |=> compare_register_b == $past(buf_reg[1]);
  endproperty
  a_pc_load: assert property (p_pc_load)
    else $error("compare not loaded at top");

  // Phase and frequency correct load at bottom with overflow
  property p_pfc_load;
    @(posedge ref_clk) disable iff (reset)
    clk_en && tick && is_pfc && at_bottom
    |=> compare_register_b == $past(buf_reg[1]) && overflow_flag;
  endproperty
  a_pfc_load: assert property (p_pfc_load)
    else $error("compare not loaded at bottom");

  // Fixed top masks written bits
  property p_mask;
    @(posedge ref_clk) disable iff (reset)
    clk_en && compare_a_write && fixed_top
    |=> (buf_reg[0] & ~$past(top_val)) == 16'h0000;
  endproperty
  a_mask: assert property (p_mask)
    else $error("compare bits above resolution not masked");

  // No match beyond the top
  property p_no_match;
    @(posedge ref_clk) disable iff (reset)
    ocr_reg[1] > top_val |-> !match[1];
  endproperty
  a_no_match: assert property (p_no_match)
    else $error("match signalled above top");

  // Match sets the channel flag
  property p_match_flag;
    @(posedge ref_clk) disable iff (reset)
    clk_en && match[1] |=> compare_flag_b;
  endproperty
  a_match_flag: assert property (p_match_flag)
    else $error("compare flag not set on match");

  // Pin enable needs the direction bit
  property p_pin_oe;
    @(posedge ref_clk) disable iff (reset)
    clk_en && !pin_direction_bit_a |=> !pin_oe_a;
  endproperty
  a_pin_oe: assert property (p_pin_oe)
    else $error("pin driven without direction bit");

  // Reset state
  property p_reset_state;
    @(posedge ref_clk)
    reset |=> counter_value == BOTTOM && !count_down && !compare_output_a;
  endproperty
  a_reset_state: assert property (p_reset_state)
    else $error("wrong state after reset");

endmodule : dual_slope_pwm_timer

/* File: inc/dual_slope_pwm_pkg.sv */
// Constants and types for the dual-slope PWM timer.
package dual_slope_pwm_pkg;
  localparam int CNT_W = 16;
  localparam int PSC_W = 10;
  // Waveform mode codes
  localparam logic [3:0] MODE_PC_8BIT = 4'h1;
  localparam logic [3:0] MODE_PC_9BIT = 4'h2;
  localparam logic [3:0] MODE_PC_10BIT = 4'h3;
  localparam logic [3:0] MODE_PFC_CAPTURE = 4'h8;
  localparam logic [3:0] MODE_PFC_COMPARE_A = 4'h9;
  localparam logic [3:0] MODE_PC_CAPTURE = 4'hA;
  localparam logic [3:0] MODE_PC_COMPARE_A = 4'hB;
  // Fixed top values
  localparam logic [15:0] TOP_8BIT = 16'h00FF;
  localparam logic [15:0] TOP_9BIT = 16'h01FF;
  localparam logic [15:0] TOP_10BIT = 16'h03FF;
  localparam logic [15:0] TOP_MIN = 16'h0003;
  localparam logic [15:0] BOTTOM = 16'h0000;
  // Output behaviour codes
  localparam logic [1:0] BEHAVE_NON_INVERT = 2'h2;
  localparam logic [1:0] BEHAVE_INVERT = 2'h3;
  // Clock select codes, 0 stops the timer
  localparam logic [2:0] CS_DIV1 = 3'h1;
  localparam logic [2:0] CS_DIV8 = 3'h2;
  localparam logic [2:0] CS_DIV64 = 3'h3;
  localparam logic [2:0] CS_DIV256 = 3'h4;
  localparam logic [2:0] CS_DIV1024 = 3'h5;
  // Prescaler count masks, tick when masked bits are all ones
  localparam logic [9:0] PSC_MASK_8 = 10'h007;
  localparam logic [9:0] PSC_MASK_64 = 10'h03F;
  localparam logic [9:0] PSC_MASK_256 = 10'h0FF;
  localparam logic [9:0] PSC_MASK_1024 = 10'h3FF;
  // Count direction
  typedef enum logic {
    DIR_UP = 1'b0,
    DIR_DOWN = 1'b1
  } dir_t;
endpackage : dual_slope_pwm_pkg

/* File: verification/pwm_load_model.sv */
// External load on one compare output pin, with a pull-up.
`timescale 1ns/100ps
module pwm_load_model (
  input wire logic ref_clk,
  input wire logic pin_out,
  input wire logic pin_oe,
  output logic pin_level,
  output logic [15:0] high_cycles
);
  // Pin level seen by the load; the pull-up wins when undriven
  assign pin_level = pin_oe ? pin_out : 1'b1;
  // Count clock cycles the load sees high
  logic [15:0] high_cnt = 16'h0000;
  assign high_cycles = high_cnt;
  always @(posedge ref_clk) begin
    if (pin_level) begin
      high_cnt <= high_cnt + 16'h0001;
    end
  end
endmodule : pwm_load_model

/* File: verification/tb_top.sv */
// Self-checking testbench for the dual-slope PWM timer.
`timescale 1ns/100ps
module tb_top;
  import dual_slope_pwm_pkg::*;
  logic ref_clk = 1'b0, reset = 1'b1, clk_en = 1'b1;
  logic [3:0] waveform_mode_field = 4'h0;
  logic [2:0] clock_select = CS_DIV1;
  logic [1:0] output_behaviour_field_a = 2'h0;
  logic [1:0] output_behaviour_field_b = 2'h0;
  logic pin_direction_bit_a = 1'b0, pin_direction_bit_b = 1'b0;
  logic compare_a_write = 1'b0, compare_b_write = 1'b0;
  logic capture_top_write = 1'b0, overflow_flag_clear = 1'b0;
  logic compare_flag_a_clear = 1'b0, compare_flag_b_clear = 1'b0;
  logic capture_flag_clear = 1'b0;
  logic [15:0] compare_write_data = 16'h0000;
  logic [15:0] capture_top_data = 16'h0000;
  logic [15:0] counter_value, compare_register_a, compare_register_b;
  logic [15:0] capture_top_register, v, top, hc_b;
  logic count_down, overflow_flag, compare_flag_a, compare_flag_b;
  logic capture_flag, compare_output_a, compare_output_b;
  logic pin_out_a, pin_oe_a, pin_out_b, pin_oe_b, level_a, level_b;
  int mismatches = 0, compares = 0, waited = 0;
  int divs[4] = '{8, 64, 256, 1024};

  dual_slope_pwm_timer u_dut (.ref_clk, .reset, .clk_en,
    .waveform_mode_field, .clock_select, .output_behaviour_field_a,
    .output_behaviour_field_b, .pin_direction_bit_a, .pin_direction_bit_b,
    .compare_a_write, .compare_b_write, .compare_write_data,
    .capture_top_write, .capture_top_data, .overflow_flag_clear,
    .compare_flag_a_clear, .compare_flag_b_clear, .capture_flag_clear,
    .counter_value, .count_down, .compare_register_a, .compare_register_b,
    .capture_top_register, .overflow_flag, .compare_flag_a, .compare_flag_b,
    .capture_flag, .compare_output_a, .compare_output_b, .pin_out_a,
    .pin_oe_a, .pin_out_b, .pin_oe_b);
  pwm_load_model u_load_a (.ref_clk, .pin_out(pin_out_a),
    .pin_oe(pin_oe_a), .pin_level(level_a), .high_cycles());
  pwm_load_model u_load_b (.ref_clk, .pin_out(pin_out_b),
    .pin_oe(pin_oe_b), .pin_level(level_b), .high_cycles(hc_b));

  // 20 MHz clock
  always #25 ref_clk = ~ref_clk;

  // Move just past the next rising edge
  task automatic tick;
    @(posedge ref_clk);
    #1;
  endtask : tick

  // Compare one value against its expectation
  task automatic chk(input string what, input logic [16:0] seen,
                     input logic [16:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // Wait, bounded, for a counter value on a given slope
  task automatic wait_at(input logic [15:0] val, input logic dn);
    tick();
    waited = 1;
    while (!(counter_value === val && count_down === dn) && waited < 3000)
    begin
      tick();
      waited++;
    end
    if (waited >= 3000) begin
      mismatches++;
      $display("CHECK FAILED wait expected %h seen %h", val, counter_value);
    end
  endtask : wait_at

  // Write one compare buffer, a strobe for one cycle
  task automatic write_cmp(input logic ch, input logic [15:0] d);
    compare_write_data = d;
    compare_a_write = ~ch;
    compare_b_write = ch;
    tick();
    compare_a_write = 1'b0;
    compare_b_write = 1'b0;
    tick();
  endtask : write_cmp

  // Clear every flag at once
  task automatic clear_flags;
    {overflow_flag_clear, compare_flag_a_clear} = 2'b11;
    {compare_flag_b_clear, capture_flag_clear} = 2'b11;
    tick();
    {overflow_flag_clear, compare_flag_a_clear} = 2'b00;
    {compare_flag_b_clear, capture_flag_clear} = 2'b00;
    tick();
  endtask : clear_flags

  // Count cycles between two counter steps
  task automatic step_len;
    v = counter_value;
    waited = 0;
    while (counter_value === v && waited < 2100) begin
      tick();
      waited++;
    end
    v = counter_value;
    waited = 0;
    while (counter_value === v && waited < 2100) begin
      tick();
      waited++;
    end
  endtask : step_len

  // Print the counts and the verdict, then stop
  task automatic summarize;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : summarize

  // Cut a hang short
  initial begin
    repeat (40000) @(posedge ref_clk);
    mismatches++;
    summarize();
  end

  // Main sequence
  initial begin
    repeat (6) tick();
    chk("counter reset", counter_value, 16'h0000);
    chk("status reset", {8'h00, count_down, overflow_flag, compare_flag_a,
        compare_flag_b, capture_flag, compare_output_a, compare_output_b,
        pin_oe_a}, 16'h0000);
    reset = 1'b0;
    tick();
    capture_top_data = 16'h0008;
    capture_top_write = 1'b1;
    tick();
    capture_top_write = 1'b0;
    write_cmp(1'b0, 16'h0003);
    write_cmp(1'b1, 16'h0009);
    output_behaviour_field_a = BEHAVE_NON_INVERT;
    output_behaviour_field_b = BEHAVE_NON_INVERT;
    pin_direction_bit_a = 1'b1;
    waveform_mode_field = MODE_PC_CAPTURE;
    clear_flags();
    // Capture top of 8, one period traced
    wait_at(16'h0008, 1'b0);
    chk("out a up", compare_output_a, 1'b0);
    chk("flag a", compare_flag_a, 1'b1);
    tick();
    chk("after top", {count_down, counter_value}, 17'h10007);
    chk("capture flag", capture_flag, 1'b1);
    wait_at(16'h0002, 1'b1);
    chk("out a down", compare_output_a, 1'b1);
    wait_at(16'h0001, 1'b0);
    chk("overflow", overflow_flag, 1'b1);
    chk("flag b above top", compare_flag_b, 1'b0);
    chk("pin a", level_a, 1'b1);
    chk("pin b undriven", {pin_oe_b, level_b}, 2'b01);
    wait_at(16'h0001, 1'b0);
    chk("period", 16'(waited), 16'h0010);
    // Both output polarities
    for (int k = 0; k < 2; k++) begin
      output_behaviour_field_a = k ? BEHAVE_INVERT : BEHAVE_NON_INVERT;
      wait_at(16'h0008, 1'b0);
      wait_at(16'h0002, 1'b1);
      chk("polarity down", compare_output_a, k ? 1'b0 : 1'b1);
      wait_at(16'h0005, 1'b0);
      chk("polarity up", compare_output_a, k ? 1'b1 : 1'b0);
    end
    // Extreme compare values
    output_behaviour_field_a = BEHAVE_NON_INVERT;
    pin_direction_bit_b = 1'b1;
    write_cmp(1'b0, 16'h0008);
    write_cmp(1'b1, 16'h0000);
    wait_at(16'h0008, 1'b0);
    wait_at(16'h0008, 1'b0);
    tick();
    v = hc_b;
    repeat (16) begin
      tick();
      chk("steady a", compare_output_a, 1'b1);
      chk("steady b", {compare_output_b, level_b}, 2'b00);
    end
    chk("load b high count", hc_b, v);
    // Phase and frequency correct, capture top
    wait_at(16'h0002, 1'b0);
    waveform_mode_field = MODE_PFC_CAPTURE;
    write_cmp(1'b1, 16'h0005);
    clear_flags();
    wait_at(16'h0008, 1'b0);
    chk("no load at top", compare_register_b, 16'h0000);
    tick();
    chk("capture flag pfc", capture_flag, 1'b1);
    wait_at(16'h0000, 1'b1);
    chk("no overflow yet", overflow_flag, 1'b0);
    tick();
    chk("load at bottom", compare_register_b, 16'h0005);
    chk("overflow pfc", overflow_flag, 1'b1);
    // Compare A as top, new top taken at bottom
    waveform_mode_field = MODE_PFC_COMPARE_A;
    write_cmp(1'b0, 16'h0006);
    wait_at(16'h0000, 1'b1);
    clear_flags();
    wait_at(16'h0006, 1'b0);
    chk("flag a before top", compare_flag_a, 1'b0);
    tick();
    chk("top from a", {count_down, counter_value}, 17'h10005);
    chk("flag a at top", compare_flag_a, 1'b1);
    // Fixed tops with masked compare writes
    waveform_mode_field = 4'h0;
    tick();
    tick();
    for (int i = 0; i < 3; i++) begin
      waveform_mode_field = MODE_PC_8BIT + 4'(i);
      top = (16'h0100 << i) - 16'h0001;
      tick();
      write_cmp(1'b0, 16'hFFFF);
      wait_at(top, 1'b0);
      tick();
      chk("fixed top", {count_down, counter_value}, {1'b1, top - 16'h1});
      chk("masked compare", compare_register_a, top);
    end
    // Prescaler dividers
    for (int i = 0; i < 4; i++) begin
      clock_select = CS_DIV8 + 3'(i);
      step_len();
      chk("divider", 16'(waited), 16'(divs[i]));
    end
    // Enable low freezes the counter
    clock_select = CS_DIV1;
    clk_en = 1'b0;
    v = counter_value;
    repeat (5) tick();
    chk("frozen", counter_value, v);
    clk_en = 1'b1;
    pin_direction_bit_a = 1'b0;
    tick();
    tick();
    chk("pin a released", {pin_oe_a, level_a}, 2'b01);
    summarize();
  end
endmodule : tb_top
